// [dv/strap_pin_model.sv]
// Purpose: far-side model of config pin strapping and reset pull-up
// Assumes: open pin rises slowly, capacitor charges slower still
// Notes:   rise times are cycles after the device lets go of the pin
`timescale 1ns/1ps
module strap_pin_model
    import supervisor_pkg::*;
#(
    parameter int unsigned OPEN_RISE = 16,
    parameter int unsigned CAP_RISE  = 70
) (
    // clock
    input  wire logic        i_clk,
    // strap choice and device enables
    input  wire delay_mode_e i_strap,
    input  wire logic        i_cfg_oe,
    input  wire logic        i_rst_oe,
    // wire levels
    output logic             o_cfg_level,
    output logic             o_rst_level
);
    int rel_cnt = 0;

    // ************************************************************
    // pin levels
    // ************************************************************
    // count cycles since release; discharge restarts the ramp
    always @(posedge i_clk) begin
        rel_cnt <= i_cfg_oe ? 0 : rel_cnt + 1;
    end

    // three strap kinds, device pull-down wins
    always_comb begin
        if (i_cfg_oe) o_cfg_level = 1'b0;
        else if (i_strap == MODE_PULLUP) o_cfg_level = 1'b1;
        else if (i_strap == MODE_OPEN) o_cfg_level = (rel_cnt >= OPEN_RISE);
        else o_cfg_level = (rel_cnt >= CAP_RISE);
    end

    // pull-up gives high once released
    assign o_rst_level = i_rst_oe ? 1'b0 : 1'b1;
endmodule : strap_pin_model

// [dv/window_supervisor_reset_delay_tb_top.sv]
// Purpose: self-checking bench for the reset-delay sequencer
// Assumes: shortened counts through top parameters
// Notes:   delay lengths counted from the edge that drops the fault
`timescale 1ns/1ps
module window_supervisor_reset_delay_tb_top
    import supervisor_pkg::*;
;
    localparam int INIT = 40;
    localparam int NC   = 60;
    localparam int PU   = 30;
    localparam int CMIN = 20;
    localparam int CMAX = 200;
    localparam int N_PU = 1 + INIT + PU;   // fault drop to pull-up release

    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_undervoltage = 1'b0;
    logic        i_overvoltage = 1'b0;
    logic        i_adjustable_variant = 1'b0;
    logic        o_cfg_pin_out, o_cfg_pin_oe;
    logic        o_sys_rst_b_out, o_sys_rst_b_oe;
    logic        cfg_level, rst_level;
    delay_mode_e strap = MODE_PULLUP;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n;

    // ************************************************************
    // clock, design, far side
    // ************************************************************
    always #2 i_clk = ~i_clk;

    window_supervisor_reset_delay #(.INIT_CYCLES(INIT), .DISCH_CYCLES(4),
        .EARLY_CYCLES(8), .RST_NC_CYCLES(NC), .RST_PU_CYCLES(PU),
        .CAP_MIN_CYCLES(CMIN), .CAP_MAX_CYCLES(CMAX))
    window_supervisor_reset_delay_inst (
        .i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_undervoltage(i_undervoltage), .i_overvoltage(i_overvoltage),
        .i_adjustable_variant(i_adjustable_variant),
        .i_cfg_pin(cfg_level), .o_cfg_pin_out(o_cfg_pin_out),
        .o_cfg_pin_oe(o_cfg_pin_oe), .o_sys_rst_b_out(o_sys_rst_b_out),
        .o_sys_rst_b_oe(o_sys_rst_b_oe));

    strap_pin_model strap_pin_model_inst (
        .i_clk(i_clk), .i_strap(strap), .i_cfg_oe(o_cfg_pin_oe),
        .i_rst_oe(o_sys_rst_b_oe), .o_cfg_level(cfg_level),
        .o_rst_level(rst_level));

    // ************************************************************
    // compare and close
    // ************************************************************
    task automatic check_bit(input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: bit %b, want %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_range(input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("wrong value at %0t: %0d cycles, want %0d..%0d",
                     $time, got, lo, hi);
        end
    endtask : check_range

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // hang guard: whole run is under a thousand cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    // undervoltage pulse, then count edges until reset lets go
    task automatic run_entry(input delay_mode_e m, output int cnt);
        strap = m;
        @(posedge i_clk) i_undervoltage <= 1'b1;
        repeat (3) @(posedge i_clk);
        check_bit(1'b1, o_sys_rst_b_oe);
        check_bit(1'b0, o_sys_rst_b_out);
        check_bit(1'b1, o_cfg_pin_oe);
        check_bit(1'b0, o_cfg_pin_out);
        i_undervoltage <= 1'b0;
        cnt = 0;
        while (o_sys_rst_b_oe !== 1'b0 && cnt < 5000) begin
            @(posedge i_clk);
            #1 cnt++;
        end
        check_bit(1'b1, rst_level);
    endtask : run_entry

    task automatic test_straps();
        run_entry(MODE_PULLUP, n);
        check_range(N_PU, N_PU, n);
        run_entry(MODE_OPEN, n);
        check_range(1 + INIT + NC, 1 + INIT + NC, n);
        run_entry(MODE_CAP, n);
        check_range(1 + INIT + CMIN, 1 + INIT + CMAX, n);
        repeat (50) @(posedge i_clk);
        check_bit(1'b0, o_sys_rst_b_oe);
        $display("strap delays done");
    endtask : test_straps

    // fault mid-delay, strap changed before the next entry
    task automatic test_restart();
        strap = MODE_PULLUP;
        @(posedge i_clk) i_undervoltage <= 1'b1;
        @(posedge i_clk) i_undervoltage <= 1'b0;
        repeat (INIT + 10) @(posedge i_clk);
        #1 check_bit(1'b1, o_sys_rst_b_oe);
        run_entry(MODE_OPEN, n);
        check_range(1 + INIT + NC, 1 + INIT + NC, n);
        $display("restart done");
    endtask : test_restart

    // overvoltage acts on the window part, not on the adjustable one
    task automatic test_overvoltage();
        @(posedge i_clk) i_overvoltage <= 1'b1;
        // strap rises one edge after overvoltage; its sync lag keeps this fault
        @(posedge i_clk) i_adjustable_variant <= 1'b1;
        #1 check_bit(1'b1, o_sys_rst_b_oe);
        run_entry(MODE_PULLUP, n);
        check_range(1 + INIT + PU, 1 + INIT + PU, n);
        repeat (8) @(posedge i_clk);
        #1 check_bit(1'b0, o_sys_rst_b_oe);
        $display("overvoltage done");
    endtask : test_overvoltage

    // reset mid-run: pins fall back at once, whole sequence reruns
    task automatic test_reset();
        @(posedge i_clk) i_rst_b <= 1'b0;
        #1 check_bit(1'b1, o_sys_rst_b_oe);
        check_bit(1'b1, o_cfg_pin_oe);
        @(posedge i_clk) i_rst_b <= 1'b1;
        n = 0;
        while (o_sys_rst_b_oe !== 1'b0 && n < 5000) begin
            @(posedge i_clk);
            #1 n++;
        end
        // strap sync restarts low, so overvoltage holds two edges more
        check_range(N_PU + 2, N_PU + 2, n);
        $display("mid-run reset done");
    endtask : test_reset

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        test_straps();
        test_restart();
        test_overvoltage();
        test_reset();
        report_and_stop();
    end
endmodule : window_supervisor_reset_delay_tb_top

// [hw/phase_counter.sv]
// Purpose: saturating cycle counter timing each supervisor phase
// Assumes: single clock, clear taken synchronously
// Notes:   saturates so a stalled phase never wraps to a short count
`timescale 1ns/1ps
module phase_counter #(
    parameter int unsigned W = 32
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    // control
    input  wire logic         i_clear,
    // count
    output logic [W-1:0]      o_count
);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;

    // next count, restart from zero on clear
    always_comb begin
        if (i_clear) begin
            count_next = '0;
        end else if (count_reg != {W{1'b1}}) begin
            count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
        end else begin
            count_next = count_reg;
        end
    end

    // count register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign o_count = count_reg;

endmodule : phase_counter

// [hw/supervisor_pkg.sv]
// Purpose: shared constants for the window supervisor reset-delay logic
// Assumes: 250 MHz core clock, times given in microseconds
// Notes:   cycle counts derive from the printed times and the clock rate
package supervisor_pkg;

    // ************************************************************
    // clock and counter geometry
    // ************************************************************
    localparam int unsigned CLK_MHZ = 250;   // 4 ns period
    localparam int unsigned CNT_W   = 32;

    // ************************************************************
    // times as printed, microseconds
    // ************************************************************
    localparam int unsigned T_INIT_US    = 381;       // pin evaluation
    localparam int unsigned T_DISCH_US   = 10;        // pin discharge phase
    localparam int unsigned T_EARLY_US   = 20;        // early pin sample
    localparam int unsigned T_RST_NC_US  = 200000;    // 200 ms, pin open
    localparam int unsigned T_RST_PU_US  = 10000;     // 10 ms, pull-up
    localparam int unsigned T_CAP_MIN_US = 703;       // capacitor least
    localparam int unsigned T_CAP_MAX_US = 3220000;   // 3.22 s, longest

    // ************************************************************
    // derived cycle counts (whole microseconds, so no rounding)
    // ************************************************************
    localparam int unsigned INIT_CYC    = T_INIT_US * CLK_MHZ;
    localparam int unsigned DISCH_CYC   = T_DISCH_US * CLK_MHZ;
    localparam int unsigned EARLY_CYC   = T_EARLY_US * CLK_MHZ;
    localparam int unsigned RST_NC_CYC  = T_RST_NC_US * CLK_MHZ;
    localparam int unsigned RST_PU_CYC  = T_RST_PU_US * CLK_MHZ;
    localparam int unsigned CAP_MIN_CYC = T_CAP_MIN_US * CLK_MHZ;
    localparam int unsigned CAP_MAX_CYC = T_CAP_MAX_US * CLK_MHZ;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_FAULT,
        ST_EVAL,
        ST_DELAY,
        ST_RUN
    } sup_state_e;

    typedef enum logic [1:0] {
        MODE_OPEN,
        MODE_PULLUP,
        MODE_CAP
    } delay_mode_e;

endpackage : supervisor_pkg

// [hw/window_supervisor_reset_delay.sv]
// Purpose: reset output sequencing for a window voltage supervisor
// Assumes: comparator flags already synchronous to i_clk
// Notes:   reset and config pins are open drain, modelled as out plus oe
`timescale 1ns/1ps
module window_supervisor_reset_delay
    import supervisor_pkg::*;
#(
    parameter int unsigned INIT_CYCLES    = INIT_CYC,
    parameter int unsigned DISCH_CYCLES   = DISCH_CYC,
    parameter int unsigned EARLY_CYCLES   = EARLY_CYC,
    parameter int unsigned RST_NC_CYCLES  = RST_NC_CYC,
    parameter int unsigned RST_PU_CYCLES  = RST_PU_CYC,
    parameter int unsigned CAP_MIN_CYCLES = CAP_MIN_CYC,
    parameter int unsigned CAP_MAX_CYCLES = CAP_MAX_CYC
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    // comparator flags
    input  wire logic i_undervoltage,
    input  wire logic i_overvoltage,
    // variant strap pin
    input  wire logic i_adjustable_variant,
    // reset_delay_config_pin, open drain
    input  wire logic i_cfg_pin,
    output logic      o_cfg_pin_out,
    output logic      o_cfg_pin_oe,
    // active-low system reset, open drain
    output logic      o_sys_rst_b_out,
    output logic      o_sys_rst_b_oe
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic        cfg_meta_reg;
    logic        cfg_sync_reg;
    logic        adj_meta_reg;
    logic        adj_sync_reg;

    // two flops each; only the second stage is read
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_meta_reg <= 1'b0;
            cfg_sync_reg <= 1'b0;
            adj_meta_reg <= 1'b0;
            adj_sync_reg <= 1'b0;
        end else begin
            cfg_meta_reg <= i_cfg_pin;
            cfg_sync_reg <= cfg_meta_reg;
            adj_meta_reg <= i_adjustable_variant;
            adj_sync_reg <= adj_meta_reg;
        end
    end

    // ************************************************************
    // fault decode and phase counter
    // ************************************************************
    logic             fault;
    logic [CNT_W-1:0] cnt;
    logic             cnt_clear;
    sup_state_e       state_reg;
    sup_state_e       state_next;

    // adjustable variant watches only undervoltage
    assign fault = i_undervoltage
                 | (i_overvoltage & ~adj_sync_reg);

    // restart the count at every change of phase
    assign cnt_clear = (state_next != state_reg);

    phase_counter #(
        .W       (CNT_W)
    ) u_phase_counter (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_clear (cnt_clear),
        .o_count (cnt)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    delay_mode_e mode_reg;
    delay_mode_e mode_next;
    logic        early_high_reg;
    logic        early_high_next;
    logic        delay_done;
    logic        rst_oe_next;
    logic        cfg_oe_next;

    // delay end per strap; capacitor ends on charge, clamped both ways
    always_comb begin
        unique case (mode_reg)
            MODE_OPEN:   delay_done = (cnt == CNT_W'(RST_NC_CYCLES - 1));
            MODE_PULLUP: delay_done = (cnt == CNT_W'(RST_PU_CYCLES - 1));
            MODE_CAP:    delay_done =
                ((cnt >= CNT_W'(CAP_MIN_CYCLES - 1)) && cfg_sync_reg)
                || (cnt >= CNT_W'(CAP_MAX_CYCLES - 1));
            default:     delay_done = 1'b1;
        endcase
    end

    // next state, mode and pin enables
    always_comb begin
        state_next      = state_reg;
        mode_next       = mode_reg;
        early_high_next = early_high_reg;
        if (fault) begin
            state_next = ST_FAULT;
        end else begin
            unique case (state_reg)
                ST_FAULT: state_next = ST_EVAL;
                ST_EVAL: begin
                    if (cnt == CNT_W'(EARLY_CYCLES)) begin
                        early_high_next = cfg_sync_reg;
                    end
                    if (cnt == CNT_W'(INIT_CYCLES - 1)) begin
                        state_next = ST_DELAY;
                        // fast rise means resistor, late rise open pin
                        if (early_high_reg) begin
                            mode_next = MODE_PULLUP;
                        end else if (cfg_sync_reg) begin
                            mode_next = MODE_OPEN;
                        end else begin
                            mode_next = MODE_CAP;
                        end
                    end
                end
                ST_DELAY: begin
                    if (delay_done) begin
                        state_next = ST_RUN;
                    end
                end
                ST_RUN:   state_next = ST_RUN;
            endcase
        end
        // reset driven low everywhere but run
        rst_oe_next = (state_next != ST_RUN);
        // discharge the config pin in fault and at start of evaluation
        cfg_oe_next = (state_next == ST_FAULT)
                    || ((state_next == ST_EVAL)
                        && ((state_reg != ST_EVAL)
                            || (cnt < CNT_W'(DISCH_CYCLES - 1))));
    end

    // sequencer registers; reset starts asserted and discharging
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg       <= ST_FAULT;
            mode_reg        <= MODE_OPEN;
            early_high_reg  <= 1'b0;
            o_sys_rst_b_oe  <= 1'b1;
            o_sys_rst_b_out <= 1'b0;
            o_cfg_pin_oe    <= 1'b1;
            o_cfg_pin_out   <= 1'b0;
        end else begin
            state_reg       <= state_next;
            mode_reg        <= mode_next;
            early_high_reg  <= early_high_next;
            o_sys_rst_b_oe  <= rst_oe_next;
            o_sys_rst_b_out <= 1'b0;   // open drain only ever pulls low
            o_cfg_pin_oe    <= cfg_oe_next;
            o_cfg_pin_out   <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    chk_fault_pulls_low: assert property (
        fault |=> o_sys_rst_b_oe && !o_sys_rst_b_out && state_reg == ST_FAULT)
        else $error("reset not driven low on fault");

    chk_run_released: assert property (
        state_reg == ST_RUN && !fault |=> !o_sys_rst_b_oe)
        else $error("reset driven while in window");

    chk_entry_holds: assert property (
        state_reg == ST_FAULT && !fault |=> state_reg == ST_EVAL
        ##0 o_sys_rst_b_oe)
        else $error("window entry did not start the sequence");

    chk_release_undriven: assert property (
        $rose(state_reg == ST_RUN) |-> !o_sys_rst_b_oe && $past(delay_done))
        else $error("release without delay end");

    chk_eval_length: assert property (
        $rose(state_reg == ST_DELAY) |->
        $past(cnt) == CNT_W'(INIT_CYCLES - 1) && $past(state_reg) == ST_EVAL)
        else $error("evaluation interval wrong");

    chk_mode_delay: assert property (
        state_reg == ST_DELAY && mode_reg == MODE_PULLUP && !fault
        && cnt == CNT_W'(RST_PU_CYCLES - 1) |=> state_reg == ST_RUN)
        else $error("pull-up delay length wrong");

    chk_class_pullup: assert property (
        state_reg == ST_EVAL && !fault && early_high_reg
        && cnt == CNT_W'(INIT_CYCLES - 1) |=> mode_reg == MODE_PULLUP)
        else $error("pull-up strap misclassified");

    chk_reeval: assert property (
        $rose(state_reg == ST_EVAL) |-> o_cfg_pin_oe ##1 state_reg != ST_EVAL
        || cnt == CNT_W'(1))
        else $error("evaluation not restarted on entry");

    chk_cap_floor: assert property (
        state_reg == ST_DELAY && mode_reg == MODE_CAP
        && cnt < CNT_W'(CAP_MIN_CYCLES - 1) |=> state_reg != ST_RUN)
        else $error("capacitor delay below floor");

    chk_adj_ov_ignored: assert property (
        adj_sync_reg && i_overvoltage && !i_undervoltage
        && state_reg == ST_RUN |=> state_reg == ST_RUN)
        else $error("adjustable variant reacted to overvoltage");

    chk_delay_restart: assert property (
        state_reg == ST_DELAY && fault |=> state_reg == ST_FAULT
        ##1 (state_reg != ST_RUN))
        else $error("fault during delay not honoured");

    cov_reach_run: cover property (
        state_reg == ST_DELAY ##1 state_reg == ST_RUN);
    cov_cap_mode: cover property (
        state_reg == ST_DELAY && mode_reg == MODE_CAP);
    cov_fault_in_delay: cover property (
        state_reg == ST_DELAY && fault);

endmodule : window_supervisor_reset_delay
